// ---- bench/sew_host_model.sv ----
// Controller model: selects, clocks frames out, captures read data.
// Assumes the bench calls one task at a time.
module sew_host_model (
    output logic      serial_clock_in,
    output logic      select_n,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;
    logic [15:0] rd_word;

    initial begin
        serial_clock_in = 1'b0;
        // Late update so the frame reset sees a real rising edge
        select_n <= 1'b1;
        serial_in = 1'b0;
    end

    // Clock idles low outside frames; n low bits of v go MSB first
    task automatic xfer(input logic [39:0] v, input int n, input bit keep);
        select_n = 1'b0;
        #HALF;
        for (int i = 0; i < n; i++) begin
            serial_in = v[n-1-i];
            #HALF;
            if (i >= 16)
                // Undriven output reads as the inverse of its level
                rd_word = {rd_word[14:0],
                           serial_out_oe ? serial_out : ~serial_out};
            serial_clock_in = 1'b1;
            #HALF;
            serial_clock_in = 1'b0;
        end
        #HALF;
        // Released data shows a changed level, never the old bit
        serial_in = ~serial_in;
        if (!keep)
            drop_select();
    endtask : xfer

    task automatic drop_select();
        select_n = 1'b1;
        #(4 * HALF);
    endtask : drop_select
endmodule : sew_host_model

// ---- bench/sew_top_monitor.sv ----
// Checker for the serial word memory top module, bound to its ports.
// Assumes the serial clock runs only while select_n is low.
module sew_top_monitor
    import sew_pkg::*;
#(
    parameter int unsigned PROG_CYCLES  = PROG_CYC,
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic serial_clock_in,
    input wire logic select_n,
    input wire logic serial_in,
    input wire logic write_abort,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic write_done_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [5:0]  sk_cnt_reg;
    logic [2:0]  op_reg;
    logic        fill_reg;
    logic [31:0] busy_cnt_reg;
    logic [7:0]  abort_hist_reg;
    logic [5:0]  sel_hist_reg;

    // Edges seen in this selection, saturating
    always_ff @(posedge serial_clock_in or posedge select_n) begin
        if (select_n)
            sk_cnt_reg <= 6'h00;
        else if (sk_cnt_reg != 6'h3f)
            sk_cnt_reg <= sk_cnt_reg + 6'h01;
    end

    // Fill-all runs as long as a write, but its busy time is not bounded here
    always_ff @(posedge serial_clock_in) begin
        op_reg <= {op_reg[1:0], serial_in};
        if (sk_cnt_reg == 6'h07)
            fill_reg <= ({op_reg, serial_in} == OP_FILL);
    end

    always_ff @(posedge sys_clk) begin
        if (srst || write_done_pin)
            busy_cnt_reg <= 32'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        abort_hist_reg <= {abort_hist_reg[6:0], write_abort};
        sel_hist_reg   <= {sel_hist_reg[4:0], select_n};
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_reset_quiet: assert property (
        $fell(srst) |-> !serial_out_oe && write_done_pin)
        else $error("outputs not idle after reset");
    a_busy_bound: assert property (
        !fill_reg |-> busy_cnt_reg <= PROG_CYCLES + 3)
        else $error("busy longer than program cycle");
    a_busy_length: assert property (
        $rose(write_done_pin) && abort_hist_reg == 8'h00 && !fill_reg
        |-> busy_cnt_reg >= PROG_CYCLES - 2)
        else $error("busy ended early without abort");
    a_busy_after_last: assert property (
        $fell(write_done_pin) |-> sk_cnt_reg == 6'h20)
        else $error("busy began away from edge 32");
    a_status_busy: assert property (
        busy_cnt_reg >= 32'h8 && sel_hist_reg == 6'h00 && !write_done_pin
        |-> serial_out_oe && !serial_out)
        else $error("busy status missing on serial out");
    a_ready_status: assert property (
        $rose(write_done_pin) && sel_hist_reg == 6'h00
        |-> ##[0:4] (serial_out_oe && serial_out))
        else $error("ready status missing on serial out");
    a_abort_ready: assert property (
        write_abort && !write_done_pin |-> ##[1:6] write_done_pin)
        else $error("abort did not end busy");
    a_deselect_quiet: assert property (
        sel_hist_reg == 6'h3f |-> !serial_out_oe)
        else $error("serial out driven while deselected");
    a_read_timing: assert property (
        $rose(serial_out_oe) && write_done_pin
        |-> sk_cnt_reg == 6'h00 || sk_cnt_reg >= 6'h10)
        else $error("serial out enabled mid frame");

    c_busy: cover property ($fell(write_done_pin));
    c_abort: cover property (write_abort && !write_done_pin);
    c_read: cover property ($rose(serial_out_oe) && sk_cnt_reg >= 6'h10);
endmodule : sew_top_monitor

bind sew_top sew_top_monitor #(
    .PROG_CYCLES  (PROG_CYCLES),
    .CLEAR_CYCLES (CLEAR_CYCLES)
) sew_top_monitor_i (
    .sys_clk         (sys_clk),
    .srst            (srst),
    .serial_clock_in (serial_clock_in),
    .select_n        (select_n),
    .serial_in       (serial_in),
    .write_abort     (write_abort),
    .serial_out      (serial_out),
    .serial_out_oe   (serial_out_oe),
    .write_done_pin  (write_done_pin)
);

// ---- bench/tb_serial_eeprom_word_access.sv ----
// Self-checking bench for the serial word memory.
// Assumes shortened program cycles so fill-all stays brief.
module tb_serial_eeprom_word_access
    import sew_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned PROG_N  = 120;
    localparam int unsigned CLEAR_N = 60;
    logic sys_clk, srst, write_abort;
    logic serial_clock_in, select_n, serial_in;
    logic serial_out, serial_out_oe, write_done_pin;
    int   n_errors   = 0;
    int   n_compared = 0;

    sew_top #(.PROG_CYCLES(PROG_N), .CLEAR_CYCLES(CLEAR_N)) sew_top_i (
        .sys_clk         (sys_clk),
        .srst            (srst),
        .serial_clock_in (serial_clock_in),
        .select_n        (select_n),
        .serial_in       (serial_in),
        .write_abort     (write_abort),
        .serial_out      (serial_out),
        .serial_out_oe   (serial_out_oe),
        .write_done_pin  (write_done_pin)
    );
    sew_host_model sew_host_model_i (
        .serial_clock_in (serial_clock_in),
        .select_n        (select_n),
        .serial_in       (serial_in),
        .serial_out      (serial_out),
        .serial_out_oe   (serial_out_oe)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic wait_ready();
        int i;
        for (i = 0; i < 40000 && write_done_pin !== 1'b1; i++)
            cyc(1);
        if (i == 40000) begin
            chk("ready wait", 16'h1, 16'h0);
            summarize();
        end
    endtask : wait_ready

    task automatic send(input logic [3:0] op, input logic [7:0] a,
                        input logic [15:0] d, input bit keep);
        sew_host_model_i.xfer({START_PAT, op, a, d}, 32, keep);
    endtask : send

    task automatic cmd(input logic [3:0] op);
        sew_host_model_i.xfer({START_PAT, op, 8'ha5}, 16, 1'b0);
    endtask : cmd

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        send(OP_READ, a, 16'h0000, 1'b0);
        chk("read word", exp, sew_host_model_i.rd_word);
        chk("idle oe", 16'h0, {15'h0, serial_out_oe});
    endtask : rd_chk

    task automatic wr_done(input logic [7:0] a, input logic [15:0] d);
        send(OP_WRITE, a, d, 1'b0);
        chk("busy pin", 16'h0, {15'h0, write_done_pin});
        wait_ready();
    endtask : wr_done

    task automatic t_write_read();
        send(OP_WRITE, 8'h10, 16'h1111, 1'b0);
        chk("locked pin", 16'h1, {15'h0, write_done_pin});
        cmd(OP_UNLOCK);
        wr_done(8'h00, 16'ha55a);
        wr_done(8'hff, 16'h5aa5);
        rd_chk(8'h00, 16'ha55a);
        rd_chk(8'hff, 16'h5aa5);
        $display("test write read done");
    endtask : t_write_read

    task automatic t_poll();
        send(OP_WRITE, 8'h3c, 16'h0f0f, 1'b1);
        cyc(8);
        chk("busy status", 16'h2, {14'h0, serial_out_oe, serial_out});
        wait_ready();
        cyc(6);
        chk("ready status", 16'h3, {14'h0, serial_out_oe, serial_out});
        sew_host_model_i.xfer(40'h1, 2, 1'b1);
        cyc(6);
        chk("status off", 16'h0, {15'h0, serial_out_oe});
        sew_host_model_i.drop_select();
        rd_chk(8'h3c, 16'h0f0f);
        $display("test poll done");
    endtask : t_poll

    task automatic t_abort();
        cyc(1);
        write_abort <= 1'b1;
        send(OP_WRITE, 8'h00, 16'h0000, 1'b1);
        cyc(6);
        chk("abort frame oe", 16'h0, {15'h0, serial_out_oe});
        chk("abort frame pin", 16'h1, {15'h0, write_done_pin});
        sew_host_model_i.drop_select();
        cyc(1);
        write_abort <= 1'b0;
        send(OP_WRITE, 8'h00, 16'h0000, 1'b0);
        cyc(1);
        write_abort <= 1'b1;
        cyc(8);
        chk("abort busy pin", 16'h1, {15'h0, write_done_pin});
        write_abort <= 1'b0;
        rd_chk(8'h00, 16'ha55a);
        $display("test abort done");
    endtask : t_abort

    task automatic t_frames();
        cyc(1);
        write_abort <= 1'b1;
        sew_host_model_i.xfer({3'b011, START_PAT, OP_READ, 8'hff, 16'h0},
                              35, 1'b0);
        chk("read abort", 16'h5aa5, sew_host_model_i.rd_word);
        cyc(1);
        write_abort <= 1'b0;
        sew_host_model_i.xfer({START_PAT, OP_WRITE, 8'hff, 4'h0},
                              20, 1'b0);
        chk("partial pin", 16'h1, {15'h0, write_done_pin});
        rd_chk(8'hff, 16'h5aa5);
        $display("test frames done");
    endtask : t_frames

    task automatic t_lock_fill();
        cyc(1);
        write_abort <= 1'b1;
        cmd(OP_LOCK);
        cyc(1);
        write_abort <= 1'b0;
        send(OP_WRITE, 8'h00, 16'h0000, 1'b0);
        chk("lock pin", 16'h1, {15'h0, write_done_pin});
        cmd(OP_UNLOCK);
        send(OP_FILL, 8'h00, 16'h1234, 1'b0);
        chk("fill pin", 16'h0, {15'h0, write_done_pin});
        wait_ready();
        rd_chk(8'h00, 16'h1234);
        rd_chk(8'hff, 16'h1234);
        $display("test lock fill done");
    endtask : t_lock_fill

    initial begin
        // Late update so the asynchronous link clears see an edge
        srst <= 1'b1;
        write_abort = 1'b0;
        cyc(8);
        srst <= 1'b0;
        #(POWERUP_READ_WAIT_US * 1us);
        t_write_read();
        t_poll();
        t_abort();
        t_frames();
        t_lock_fill();
        summarize();
    end
endmodule : tb_serial_eeprom_word_access

// ---- hdl/sew_prog_seq.sv ----
// Self-timed clear-then-program sequencer on the system clock.
// Assumes start arrives only while idle and abort is already synchronised.
module sew_prog_seq
    import sew_pkg::*;
#(
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC,
    parameter int unsigned PROG_CYCLES  = PROG_CYC - CLEAR_CYC
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    sew_prog_if.seq   pif
);
    localparam int unsigned MAXC =
        (CLEAR_CYCLES > PROG_CYCLES) ? CLEAR_CYCLES : PROG_CYCLES;
    localparam int unsigned CW = $clog2(MAXC + 1);

    sew_seq_t      state_reg;
    sew_seq_t      state_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic          phase_end;

    assign phase_end = (cnt_reg == '0);

    always_comb begin
        state_next = state_reg;
        cnt_next   = phase_end ? '0 : cnt_reg - 1'b1;
        unique case (state_reg)
            SEW_IDLE: if (pif.start) begin
                state_next = SEW_CLEAR;
                cnt_next   = CW'(CLEAR_CYCLES - 1);
            end
            SEW_CLEAR: if (pif.abort) begin
                state_next = SEW_IDLE;
            end else if (phase_end) begin
                state_next = SEW_PROG;
                cnt_next   = CW'(PROG_CYCLES - 1);
            end
            SEW_PROG: if (pif.abort || phase_end) begin
                state_next = SEW_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg <= SEW_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Abort mid-program leaves the erased word behind
    assign pif.busy      = (state_reg != SEW_IDLE);
    assign pif.clear_end = (state_reg == SEW_CLEAR) && phase_end && !pif.abort;
    assign pif.prog_end  = (state_reg == SEW_PROG) && phase_end && !pif.abort;
    assign pif.done      = pif.busy && (pif.abort || pif.prog_end);
endmodule : sew_prog_seq

// ---- hdl/sew_top.sv ----
// Serial word memory: frame decoder and read shifter on the serial
// clock; lock state, write sequencing, word store and pins on sys_clk.
// Assumes the serial clock runs only while selected and that select
// high acts as the frame reset of the serial-clock logic.
module sew_top
    import sew_pkg::*;
#(
    parameter int unsigned PROG_CYCLES  = PROG_CYC,
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC
) (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic serial_clock_in,
    input  wire logic select_n,
    input  wire logic serial_in,
    input  wire logic write_abort,
    output logic      serial_out,
    output logic      serial_out_oe,
    output logic      write_done_pin
);

    function automatic logic is_prog_op(input logic [3:0] op);
        return (op == OP_WRITE) || (op == OP_FILL);
    endfunction : is_prog_op

    // Word store: written on sys_clk only, read on the serial clock
    logic [DATA_W-1:0] mem [WORDS];

    // Serial-clock domain
    sew_link_t         lk_state_reg;
    sew_link_t         lk_state_next;
    logic [2:0]        hist_reg;
    logic [3:0]        cnt_reg;
    logic [3:0]        cnt_next;
    logic              labt_s1_reg;
    logic              labt_s2_reg;
    logic              labt_seen_reg;
    logic [3:0]        op_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic              cmd_tgl_reg;
    logic              one_tgl_reg;
    logic              cmd_fire;
    logic              start_hit;
    logic              frame_abort;
    logic              one_seen;
    logic [4:0]        rd_cnt_reg;
    logic [DATA_W-1:0] rd_word_reg;
    logic              rd_oe_reg;
    logic              rd_active;

    // System-clock domain
    localparam int unsigned NSY = 6;
    logic [NSY-1:0]    sy1_reg;
    logic [NSY-1:0]    sy2_reg;
    logic              cmd_last_reg;
    logic              one_last_reg;
    logic              cmd_ev;
    logic              one_ev;
    logic              sel_low;
    logic              abt_sync;
    logic              rd_bit_sync;
    logic              rd_oe_sync;
    logic              unlocked_reg;
    logic              wr_fill_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [DATA_W-1:0] wr_data_reg;
    logic              stat_hold_reg;
    logic              accept;
    logic              drive_status;
    logic              mem_we;
    logic [DATA_W-1:0] mem_wdata;
    logic              serial_out_reg;
    logic              serial_out_oe_reg;
    logic              write_done_pin_reg;

    sew_prog_if pif ();

    sew_prog_seq #(
        .CLEAR_CYCLES (CLEAR_CYCLES),
        .PROG_CYCLES  (PROG_CYCLES - CLEAR_CYCLES)
    ) u_seq (
        .sys_clk (sys_clk),
        .srst    (srst),
        .pif     (pif)
    );

    // Frame decode on the serial clock

    assign start_hit   = ({hist_reg, serial_in} == START_PAT);
    assign frame_abort = labt_seen_reg || labt_s2_reg;
    assign one_seen    = !select_n && serial_in;

    always_comb begin
        lk_state_next = lk_state_reg;
        cnt_next      = cnt_reg + 4'h1;
        cmd_fire      = 1'b0;
        unique case (lk_state_reg)
            SEW_HUNT: begin
                cnt_next = '0;
                if (start_hit) begin
                    lk_state_next = SEW_OPC;
                end
            end
            SEW_OPC: if (cnt_reg[1:0] == OPC_LAST) begin
                lk_state_next = SEW_ADDR;
                cnt_next      = '0;
            end
            SEW_ADDR: if (cnt_reg[2:0] == ADDR_LAST) begin
                cnt_next = '0;
                if (op_reg == OP_READ) begin
                    lk_state_next = SEW_READ;
                end else if (is_prog_op(op_reg)) begin
                    lk_state_next = SEW_DATA;
                end else begin
                    // Field is filler; other codes are dropped
                    lk_state_next = SEW_DONE;
                    cmd_fire = (op_reg == OP_UNLOCK) ||
                               (op_reg == OP_LOCK);
                end
            end
            SEW_DATA: if (cnt_reg == DATA_LAST) begin
                lk_state_next = SEW_DONE;
                cmd_fire      = !frame_abort;
            end
            SEW_READ, SEW_DONE: begin
                cnt_next = cnt_reg;
            end
        endcase
    end

    // Select high wipes any partial frame
    always_ff @(posedge serial_clock_in or posedge select_n) begin
        if (select_n) begin
            lk_state_reg  <= SEW_HUNT;
            hist_reg      <= '0;
            cnt_reg       <= '0;
            labt_s1_reg   <= 1'b0;
            labt_s2_reg   <= 1'b0;
            labt_seen_reg <= 1'b0;
        end else begin
            lk_state_reg  <= lk_state_next;
            hist_reg      <= {hist_reg[1:0], serial_in};
            cnt_reg       <= cnt_next;
            labt_s1_reg   <= write_abort;
            labt_s2_reg   <= labt_s1_reg;
            labt_seen_reg <= labt_seen_reg || labt_s2_reg;
        end
    end

    // Fields and toggles outlive the frame so sys_clk can pick them up
    always_ff @(posedge serial_clock_in or posedge srst) begin
        if (srst) begin
            op_reg      <= '0;
            addr_reg    <= '0;
            data_reg    <= '0;
            cmd_tgl_reg <= 1'b0;
            one_tgl_reg <= 1'b0;
        end else begin
            if (lk_state_reg == SEW_OPC) begin
                op_reg <= {op_reg[2:0], serial_in};
            end
            if (lk_state_reg == SEW_ADDR) begin
                addr_reg <= {addr_reg[ADDR_W-2:0], serial_in};
            end
            if (lk_state_reg == SEW_DATA) begin
                data_reg <= {data_reg[DATA_W-2:0], serial_in};
            end
            if (cmd_fire) begin
                cmd_tgl_reg <= !cmd_tgl_reg;
            end
            if (one_seen) begin
                one_tgl_reg <= !one_tgl_reg;
            end
        end
    end

    // Read shifter on the falling edge; abort is not looked at here
    assign rd_active = (lk_state_reg == SEW_READ) && (rd_cnt_reg != READ_BITS);

    always_ff @(negedge serial_clock_in or posedge select_n) begin
        if (select_n) begin
            rd_cnt_reg  <= '0;
            rd_word_reg <= '0;
            rd_oe_reg   <= 1'b0;
        end else if (rd_active) begin
            rd_cnt_reg <= rd_cnt_reg + 5'h1;
            rd_oe_reg  <= 1'b1;
            if (rd_cnt_reg == '0) begin
                rd_word_reg <= mem[addr_reg];
            end else begin
                rd_word_reg <= {rd_word_reg[DATA_W-2:0], 1'b0};
            end
        end else begin
            rd_oe_reg <= 1'b0;
        end
    end

    // Crossing into sys_clk: two flops per bit, toggles for events

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sy1_reg      <= {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            sy2_reg      <= {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
            cmd_last_reg <= 1'b0;
            one_last_reg <= 1'b0;
        end else begin
            sy1_reg <= {cmd_tgl_reg, one_tgl_reg, select_n,
                        write_abort, rd_word_reg[DATA_W-1], rd_oe_reg};
            sy2_reg      <= sy1_reg;
            cmd_last_reg <= sy2_reg[5];
            one_last_reg <= sy2_reg[4];
        end
    end

    assign cmd_ev      = sy2_reg[5] ^ cmd_last_reg;
    assign one_ev      = sy2_reg[4] ^ one_last_reg;
    assign sel_low     = !sy2_reg[3];
    assign abt_sync    = sy2_reg[2];
    assign rd_bit_sync = sy2_reg[1];
    assign rd_oe_sync  = sy2_reg[0];

    // Write acceptance and lock state

    // Frame fields are stable here: the toggle lagged them by two flops
    assign accept = cmd_ev && is_prog_op(op_reg) && unlocked_reg
                    && !abt_sync && !pif.busy;

    assign pif.start = accept;
    assign pif.abort = abt_sync;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            unlocked_reg <= 1'b0;
            wr_fill_reg  <= 1'b0;
            wr_addr_reg  <= '0;
            wr_data_reg  <= '0;
        end else begin
            // Lock and unlock never consult the abort input
            if (cmd_ev && (op_reg == OP_UNLOCK)) begin
                unlocked_reg <= 1'b1;
            end else if (cmd_ev && (op_reg == OP_LOCK)) begin
                unlocked_reg <= 1'b0;
            end
            if (accept) begin
                wr_fill_reg <= (op_reg == OP_FILL);
                wr_addr_reg <= addr_reg;
                wr_data_reg <= data_reg;
            end
        end
    end

    // Word store write port: erase at end of clear, data at end of program

    assign mem_we    = pif.clear_end || pif.prog_end;
    assign mem_wdata = pif.clear_end ? ERASED_WORD : wr_data_reg;

    // Fill-all touches every word at once; costs a wide write decode
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < WORDS; i++) begin
            if (mem_we && (wr_fill_reg || wr_addr_reg == ADDR_W'(i))) begin
                mem[i] <= mem_wdata;
            end
        end
    end

    // Status shown on the serial output

    // A late event wins over the clearing one bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stat_hold_reg <= 1'b0;
        end else if (pif.done) begin
            stat_hold_reg <= 1'b1;
        end else if (one_ev) begin
            stat_hold_reg <= 1'b0;
        end
    end

    assign drive_status = sel_low && (pif.busy || stat_hold_reg);

    // Status wins over read data if a read overlaps a program cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            serial_out_reg     <= 1'b0;
            serial_out_oe_reg  <= 1'b0;
            write_done_pin_reg <= READY_LEVEL;
        end else begin
            serial_out_oe_reg <= drive_status || rd_oe_sync;
            if (drive_status) begin
                serial_out_reg <= !pif.busy;
            end else begin
                serial_out_reg <= rd_bit_sync;
            end
            // Select is not an input of this pin on purpose
            write_done_pin_reg <= !(pif.start ||
                                    (pif.busy && !pif.done));
        end
    end

    assign serial_out     = serial_out_reg;
    assign serial_out_oe  = serial_out_oe_reg;
    assign write_done_pin = write_done_pin_reg;

endmodule : sew_top

// ---- shared/sew_pkg.sv ----
// Constants and types shared by the serial word memory block.
// Assumes a 100 MHz system clock and a much slower serial clock.
package sew_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WORDS  = 256;

    localparam logic [3:0] START_PAT = 4'ha;
    localparam logic [3:0] OP_READ   = 4'h8;
    localparam logic [3:0] OP_WRITE  = 4'h4;
    localparam logic [3:0] OP_UNLOCK = 4'h3;
    localparam logic [3:0] OP_LOCK   = 4'h0;
    localparam logic [3:0] OP_FILL   = 4'h1;

    localparam logic [1:0]  OPC_LAST    = 2'h3;
    localparam logic [2:0]  ADDR_LAST   = 3'h7;
    localparam logic [3:0]  DATA_LAST   = 4'hf;
    localparam logic [4:0]  READ_BITS   = 5'h10;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic        READY_LEVEL = 1'b1;

    localparam int unsigned SYS_CLK_KHZ  = 100000;
    // Faster figure used so both supply ranges are met
    localparam int unsigned PROG_TIME_US = 5000;
    localparam int unsigned PROG_CYC     = PROG_TIME_US * SYS_CLK_KHZ / 1000;
    localparam int unsigned CLEAR_CYC    = PROG_CYC / 2;
    // Controller-side waits after supply is stable
    localparam int unsigned POWERUP_READ_WAIT_US    = 10;
    localparam int unsigned POWERUP_PROGRAM_WAIT_US = 1000;

    typedef enum logic [2:0] {
        SEW_HUNT, SEW_OPC, SEW_ADDR, SEW_DATA, SEW_READ, SEW_DONE
    } sew_link_t;

    typedef enum logic [1:0] {
        SEW_IDLE, SEW_CLEAR, SEW_PROG
    } sew_seq_t;
endpackage : sew_pkg

// ---- shared/sew_prog_if.sv ----
// Handshake between the write controller and the program sequencer.
// Assumes both ends sit on the system clock.
interface sew_prog_if;
    logic start;
    logic abort;
    logic busy;
    logic clear_end;
    logic prog_end;
    logic done;

    modport ctl (
        output start,
        output abort,
        input  busy,
        input  clear_end,
        input  prog_end,
        input  done
    );

    modport seq (
        input  start,
        input  abort,
        output busy,
        output clear_end,
        output prog_end,
        output done
    );
endinterface : sew_prog_if
